// File: rtl/ee_host.sv
// Two-wire bus master with a classic Wishbone register port
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ee_host
  import ee_pkg::*;
#(
  parameter int HALF       = EE_SCL_HALF,
  parameter int ADDR_BYTES = EE_ADDR_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  ee_if.master             bus,
  output logic             busy
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_START,
    H_LO,
    H_HI,
    H_WAIT,
    H_SP1,
    H_SP2
  } ee_hst_e;

  typedef struct packed {
    ee_hst_e     st;
    logic [7:0]  tm;
    logic [3:0]  bitn;
    logic [1:0]  idx;
    logic [7:0]  sh;
    logic [2:0]  cs;
    logic        rw;
    logic        poll;
    logic [7:0]  cnt;
    logic [15:0] addr;
    logic [7:0]  dat;
    logic        full;
    logic        nack;
    logic        busy;
    logic        scl_oe;
    logic        sda_oe;
    logic        ack;
    logic [31:0] rdat;
  } ee_hst_s;

  ee_hst_s q;
  ee_hst_s d;
  logic    sda_s;

  ee_sync #(
    .W  (1),
    .RV (1'b1)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       (bus.sda),
    .q       (sda_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bit engine and register port
  always_comb begin
    logic       ld;
    logic       fin;
    logic [7:0] nb;
    ld  = 1'b0;
    fin = 1'b0;
    nb  = 8'h00;
    d   = q;
    d.ack = 1'b0;
    if (q.st == H_WAIT) begin
      if (q.full) begin
        ld     = 1'b1;
        nb     = q.dat;
        d.full = 1'b0;
        d.cnt  = q.cnt - 8'h1;
        d.idx  = 2'h3;
      end
    end else if (q.st != H_IDLE) begin
      if (q.tm != 8'h0) begin
        d.tm = q.tm - 8'h1;
      end else begin
        d.tm = 8'(HALF - 1);
        case (q.st)
          H_START: begin
            d.scl_oe = 1'b1;
            ld       = 1'b1;
            nb       = {EE_DEV_CODE, q.cs, q.rw};       // [RL1] [RL3]
            d.idx    = 2'h0;
          end
          H_LO: begin
            d.scl_oe = 1'b0;
            d.st     = H_HI;
          end
          H_HI: begin
            d.scl_oe = 1'b1;
            if (q.bitn != 4'h8) begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.bitn   = q.bitn + 4'h1;
              d.sda_oe = (q.bitn == 4'h7) ? 1'b0 : !q.sh[6]; // [RL23]
              d.st     = H_LO;
            end else if (sda_s) begin
              d.nack = 1'b1;                            // [RL24]
              fin    = 1'b1;
            end else begin
              case (q.idx)
                2'h0: begin
                  if (q.poll || q.rw) begin             // [RL24]
                    fin = 1'b1;
                  end else if (ADDR_BYTES == 2) begin   // [RL4]
                    ld    = 1'b1;
                    nb    = q.addr[15:8];
                    d.idx = 2'h1;
                  end else begin
                    ld    = 1'b1;
                    nb    = q.addr[7:0];
                    d.idx = 2'h2;
                  end
                end
                2'h1: begin
                  ld    = 1'b1;
                  nb    = q.addr[7:0];
                  d.idx = 2'h2;
                end
                default: begin
                  if (q.cnt == 8'h0) begin
                    fin = 1'b1;                         // [RL14]
                  end else if (q.full) begin
                    ld     = 1'b1;
                    nb     = q.dat;
                    d.full = 1'b0;
                    d.cnt  = q.cnt - 8'h1;
                    d.idx  = 2'h3;
                  end else begin
                    d.st = H_WAIT;
                  end
                end
              endcase
            end
          end
          H_SP1: begin
            d.scl_oe = 1'b0;
            d.st     = H_SP2;
          end
          H_SP2: begin
            d.sda_oe = 1'b0;                            // [RL23]
            d.busy   = 1'b0;
            d.st     = H_IDLE;
          end
          default: begin
            d.st = H_IDLE;
          end
        endcase
      end
    end
    if (ld) begin
      d.sh     = nb;
      d.sda_oe = !nb[7];
      d.bitn   = 4'h0;
      d.tm     = 8'(HALF - 1);
      d.st     = H_LO;
    end
    if (fin) begin
      d.sda_oe = 1'b1;
      d.st     = H_SP1;
    end
    // Register port, single-cycle answer; a data write wins over a take
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      case (wb_adr_i)
        EE_REG_CMD:  d.rdat = {16'h0, q.cnt, 3'h0, q.poll, q.rw, q.cs};
        EE_REG_ADDR: d.rdat = {16'h0, q.addr};
        EE_REG_DATA: d.rdat = {24'h0, q.dat};
        EE_REG_STAT: d.rdat = {29'h0, q.full, q.nack, q.busy};
        default:     d.rdat = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          EE_REG_CMD: begin
            if (!q.busy && wb_dat_i[EE_CMD_GO]) begin
              d.cs     = wb_dat_i[EE_CMD_CS_LSB+:3];    // [RL9] [RL10]
              d.rw     = wb_dat_i[EE_CMD_RW];
              d.poll   = wb_dat_i[EE_CMD_POLL];
              d.cnt    = wb_dat_i[EE_CMD_CNT_LSB+:8];
              d.busy   = 1'b1;
              d.nack   = 1'b0;
              d.sda_oe = 1'b1;                          // [RL23]
              d.tm     = 8'(HALF - 1);
              d.st     = H_START;
            end
          end
          EE_REG_ADDR: d.addr = wb_dat_i[15:0];
          EE_REG_DATA: begin
            d.dat  = wb_dat_i[7:0];
            d.full = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q    <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o     = q.rdat;
  assign wb_ack_o     = q.ack;
  assign busy         = q.busy;
  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = q.scl_oe;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = q.sda_oe;
endmodule
`default_nettype wire

// File: inc/ee_pkg.sv
// Shared constants for the two-wire EEPROM slave and its bus master
package ee_pkg;
  // Control byte layout
  localparam logic [3:0] EE_DEV_CODE   = 4'hA;
  localparam int         EE_CODE_LSB   = 4;
  localparam int         EE_CS_LSB     = 1;
  localparam int         EE_RW_BIT     = 0;
  localparam int         EE_BYTE_BITS  = 8;
  // Array shape defaults
  localparam int         EE_ADDR_W     = 12;
  localparam int         EE_ADDR_BYTES = 2;
  localparam int         EE_PAGE_BYTES = 32;
  // Timing
  localparam int         EE_CLK_NS     = 10;
  localparam int         EE_WR_TIME_NS = 5000000;
  localparam int         EE_WR_CYC     = EE_WR_TIME_NS / EE_CLK_NS;
  localparam int         EE_SCL_PER_NS = 80;
  localparam int         EE_SCL_HALF   = EE_SCL_PER_NS / (2 * EE_CLK_NS);
  // Host register offsets
  localparam logic [7:0] EE_REG_CMD    = 8'h00;
  localparam logic [7:0] EE_REG_ADDR   = 8'h04;
  localparam logic [7:0] EE_REG_DATA   = 8'h08;
  localparam logic [7:0] EE_REG_STAT   = 8'h0C;
  // Command register fields
  localparam int         EE_CMD_CS_LSB = 0;
  localparam int         EE_CMD_RW     = 3;
  localparam int         EE_CMD_POLL   = 4;
  localparam int         EE_CMD_GO     = 5;
  localparam int         EE_CMD_CNT_LSB = 8;
  // Status register fields
  localparam int         EE_ST_BUSY    = 0;
  localparam int         EE_ST_NACK    = 1;
  localparam int         EE_ST_FULL    = 2;
endpackage

// File: inc/ee_if.sv
// Open-drain two-wire link between the master and the EEPROM slave
`timescale 1ns/100ps
`default_nettype none
interface ee_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

// File: rtl/ee_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module ee_sync #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ee_sync_s;

  ee_sync_s r_q;
  ee_sync_s r_d;

  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= {RV, RV};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule
`default_nettype wire

// File: rtl/ee_dev.sv
// Serial EEPROM slave: addressing, byte and page write, simple read
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Contract
// [RL1] Control byte code must be 1010
// [RL2] Selection bits must match chip-select pins
// [RL3] Last control bit: one read, zero write
// [RL4] Two address bytes, high byte first
// [RL5] Unused high address bits ignored by density
// [RL6] Matching control byte gets acknowledged
// [RL7] Segment bit picks half; no crossing; a sequential read here carries into the segment bit
// [RL8] Top pin high; segment bit in place
// [RL9] Small package: master sends zero bits
// [RL10] Selection bits as upper address; no spill
// [RL11] Control byte acknowledged on ninth clock
// [RL12] Address bytes acknowledged, loaded to counter
// [RL13] Tiny device uses low four address bits
// [RL14] Data byte acknowledged; Stop starts write
// [RL15] Protected: acknowledge, no write, stay ready
// [RL16] Counter advances after each write byte
// [RL17] No acknowledge during internal write cycle
// [RL18] Page buffer holds bytes until Stop
// [RL19] Over one page wraps and overwrites
// [RL20] Any start, any count, only addressed change
// [RL21] Protect low allows normal writes
// [RL22] Page size parameter; wrap low bits only
// [RL23] Start and Stop only while clock high
// [RL24] Master polls control byte until acknowledged; the host sends it once per poll command and flags a nack
module ee_dev
  import ee_pkg::*;
#(
  parameter int ADDR_W     = EE_ADDR_W,
  parameter int ADDR_BYTES = EE_ADDR_BYTES,
  parameter int PAGE       = EE_PAGE_BYTES,
  parameter bit SEG_MODE   = 1'b0,
  parameter int WR_CYC     = EE_WR_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  ee_if.slave             bus,
  input  wire logic [2:0] chip_sel,
  input  wire logic       wp,
  output logic            busy
);
  localparam int PW = $clog2(PAGE);

  typedef enum logic [2:0] {
    S_IDLE,
    S_CTRL,
    S_ADRH,
    S_ADRL,
    S_DATA,
    S_RD,
    S_SKIP
  } ee_dev_e;

  typedef struct packed {
    ee_dev_e           st;
    logic [7:0]        sh;
    logic [3:0]        cnt;
    logic              ackph;
    logic              oe;
    logic              seg;
    logic [7:0]        hb;
    logic [ADDR_W-1:0] addr;
    logic [PAGE-1:0]   vld;
    logic [31:0]       wcnt;
    logic              wbusy;
    logic              scl_p;
    logic              sda_p;
  } ee_dev_s;

  ee_dev_s     q;
  ee_dev_s     d;
  logic [7:0]  mem  [2**ADDR_W];
  logic [7:0]  pbuf [PAGE];
  logic [5:0]  pins;
  logic        scl;
  logic        sda;
  logic        wp_s;
  logic [2:0]  cs_s;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        code_ok;
  logic        cs_ok;
  logic        pb_we;
  logic        commit;
  logic [7:0]  rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ee_sync #(
    .W  (6),
    .RV (6'h30)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .d       ({bus.scl, bus.sda, wp, chip_sel}),
    .q       (pins)
  );

  assign scl     = pins[5];
  assign sda     = pins[4];
  assign wp_s    = pins[3];
  assign cs_s    = pins[2:0];
  assign rise    = scl && !q.scl_p;
  assign fall    = !scl && q.scl_p;
  assign start   = scl && q.scl_p && q.sda_p && !sda;   // [RL23]
  assign stop    = scl && q.scl_p && !q.sda_p && sda;   // [RL23]
  assign rd_byte = mem[q.addr];

  // Control byte checks
  assign code_ok = q.sh[7:EE_CODE_LSB] == EE_DEV_CODE;  // [RL1]
  always_comb begin
    if (SEG_MODE) begin
      cs_ok = q.sh[EE_CS_LSB+1:EE_CS_LSB] == cs_s[1:0];  // [RL8]
    end else begin
      cs_ok = q.sh[EE_CS_LSB+2:EE_CS_LSB] == cs_s;       // [RL2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d       = q;
    pb_we   = 1'b0;
    commit  = 1'b0;
    d.scl_p = scl;
    d.sda_p = sda;
    if (q.wcnt != 32'h0) begin
      d.wcnt = q.wcnt - 32'h1;
    end
    if (start) begin
      d.st    = S_CTRL;
      d.cnt   = 4'h0;
      d.ackph = 1'b0;
      d.oe    = 1'b0;
      d.vld   = '0;
    end else if (stop) begin
      if (q.st == S_DATA && (|q.vld) && !wp_s) begin    // [RL21]
        commit = 1'b1;                                  // [RL14] [RL18]
        d.wcnt = 32'(WR_CYC);
      end
      d.st    = S_IDLE;                                 // [RL15]
      d.oe    = 1'b0;
      d.ackph = 1'b0;
    end else if (q.st == S_RD) begin
      if (rise) begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'h8 && sda) begin
          d.st = S_SKIP;
          d.oe = 1'b0;
        end
      end else if (fall) begin
        if (q.cnt == 4'h9) begin
          d.sh   = rd_byte;
          d.oe   = !rd_byte[7];
          d.cnt  = 4'h0;
          d.addr = q.addr + 1'b1;
        end else if (q.cnt == 4'h8) begin
          d.oe = 1'b0;
        end else if (q.cnt != 4'h0) begin
          d.sh = {q.sh[6:0], 1'b0};
          d.oe = !q.sh[6];
        end
      end
    end else if (q.st != S_IDLE && q.st != S_SKIP) begin
      if (rise && !q.ackph) begin
        d.sh  = {q.sh[6:0], sda};
        d.cnt = q.cnt + 4'h1;
      end
      if (fall && q.ackph) begin
        d.ackph = 1'b0;
        d.oe    = 1'b0;
        d.cnt   = 4'h0;
        if (q.st == S_RD) begin
          d.cnt = 4'h9;
        end
      end else if (fall && q.cnt == 4'h8) begin
        d.ackph = 1'b1;                                 // [RL11]
        case (q.st)
          S_CTRL: begin
            if (code_ok && cs_ok && !q.wbusy) begin     // [RL17]
              d.oe  = 1'b1;                             // [RL6]
              d.seg = q.sh[EE_CS_LSB+2];                // [RL7]
              d.hb  = 8'h00;
              if (q.sh[EE_RW_BIT]) begin                // [RL3]
                d.st = S_RD;
              end else if (ADDR_BYTES == 2) begin       // [RL4]
                d.st = S_ADRH;
              end else begin
                d.st = S_ADRL;
              end
            end else begin
              d.st    = S_SKIP;
              d.ackph = 1'b0;
            end
          end
          S_ADRH: begin
            d.hb = q.sh;
            d.oe = 1'b1;                                // [RL12]
            d.st = S_ADRL;
          end
          S_ADRL: begin
            // Bits above the array width drop out here
            d.addr = ADDR_W'({SEG_MODE & q.seg, q.hb, q.sh}); // [RL5] [RL13]
            d.oe   = 1'b1;                              // [RL12]
            d.st   = S_DATA;
          end
          S_DATA: begin
            pb_we                 = 1'b1;               // [RL18] [RL20]
            d.vld[q.addr[PW-1:0]] = 1'b1;               // [RL19]
            d.addr = {q.addr[ADDR_W-1:PW],
                      PW'(q.addr[PW-1:0] + 1'b1)};      // [RL16] [RL22] [RL7]
            d.oe   = 1'b1;                              // [RL14] [RL15]
          end
          default: begin
            d.st = S_SKIP;
          end
        endcase
      end
    end
    d.wbusy = d.wcnt != 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.st    <= S_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Page buffer and array
  always_ff @(posedge clk_sys) begin
    if (pb_we) begin
      pbuf[q.addr[PW-1:0]] <= q.sh;                     // [RL19]
    end
    if (commit) begin
      for (int i = 0; i < PAGE; i++) begin
        if (q.vld[i]) begin                             // [RL20]
          mem[{q.addr[ADDR_W-1:PW], PW'(i)}] <= pbuf[i]; // [RL22]
        end
      end
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = q.oe;
  assign busy         = q.wbusy;
endmodule
`default_nettype wire

// File: verif/ee_monitor.sv
// Concurrent checks on the two-wire link between master and slave
`timescale 1ns/100ps
`default_nettype none
module ee_monitor #(
  parameter int WR_CYC = 400
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic busy
);
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_q;
  logic [15:0] cnt_q;
  //////////////////////////////////////////////////////////////////////
  // Bit position in byte, write cycle length
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      bit_q <= 4'h0;
      cnt_q <= 16'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt_q <= busy ? cnt_q + 16'h1 : 16'h0;
      if (scl && scl_q && sda_q && !sda) begin
        bit_q <= 4'h0;
      end else if (scl && !scl_q) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_NO_ACK_BUSY: assert property (busy |-> !sda_s_oe)
    else $error("slave acknowledged during write cycle");
  AST_SLV_SDA_LOW: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved data line while clock high");
  AST_MST_SDA_RISE: assert property (scl && !scl_q |-> $stable(sda_m_oe))
    else $error("master moved data line at clock rise");
  AST_ACK_HOLD: assert property ($rose(sda_s_oe) |-> sda_s_oe[*7])
    else $error("acknowledge released early");
  AST_ACK_COVER: assert property ($rose(sda_s_oe) |-> ##[1:6] (scl && !scl_q))
    else $error("acknowledge not followed by clock pulse");
  AST_ACK_NINTH: assert property (scl && !scl_q && sda_s_oe |-> bit_q == 4'h8)
    else $error("acknowledge not on ninth clock");
  AST_BUSY_IDLE: assert property ($rose(busy) |-> scl && sda)
    else $error("write cycle started without stop");
  AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_q >= WR_CYC - 1 && cnt_q <= WR_CYC + 1)
    else $error("write cycle length wrong");
  cover property ($rose(busy));
  cover property ($rose(sda_s_oe));
  cover property (scl && !scl_q && bit_q == 4'h8 && sda);
endmodule
`default_nettype wire

// File: verif/test_eeprom_i2c_addr_write.sv
// Bench joining the two-wire master and the slave over the link
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_i2c_addr_write import ee_pkg::*;;
  localparam logic [2:0] CS = 3'h5;
  localparam int         WR = 400;
  logic        clk_sys = 1'h0;
  logic        resetn  = 1'h0;
  logic        wb_cyc  = 1'h0;
  logic        wb_stb  = 1'h0;
  logic        wb_we   = 1'h0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_dat  = 32'h0;
  logic [3:0]  wb_sel  = 4'hF;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        h_busy;
  logic        d_busy;
  logic        wp      = 1'h0;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cyc_n       = 0;
  logic [7:0]  seen [3];
  logic [7:0]  sh;
  logic        sclq    = 1'h1;
  logic        sdaq    = 1'h1;
  int          nb      = 0;
  int          bi      = 0;
  ee_if bus_a ();
  ee_if bus_b ();
  ee_host #(.HALF(4), .ADDR_BYTES(2)) u_ee_host (
    .clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .bus(bus_a), .busy(h_busy));
  ee_dev #(.WR_CYC(WR)) u_ee_dev (
    .clk_sys(clk_sys), .resetn(resetn), .bus(bus_a), .chip_sel(CS),
    .wp(wp), .busy(d_busy));
  ee_dev #(.WR_CYC(WR), .ADDR_W(17), .SEG_MODE(1'b1)) u_ee_dev_b (
    .clk_sys(clk_sys), .resetn(resetn), .bus(bus_b), .chip_sel(CS),
    .wp(1'h0), .busy());
  ee_monitor #(.WR_CYC(WR)) u_ee_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .scl(bus_a.scl),
    .sda(bus_a.sda), .sda_m_oe(bus_a.sda_m_oe),
    .sda_s_oe(bus_a.sda_s_oe), .busy(d_busy));
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  // Bytes seen on the wire after each start
  always @(posedge clk_sys) begin
    if (sclq && bus_a.scl && sdaq && !bus_a.sda) begin
      nb = 0;
      bi = 0;
    end else if (!sclq && bus_a.scl) begin
      if (bi < 8) sh = {sh[6:0], bus_a.sda};
      bi++;
      if (bi == 8 && nb < 3) seen[nb] = sh;
      if (bi == 9) begin
        bi = 0;
        nb++;
      end
    end
    sclq <= bus_a.scl;
    sdaq <= bus_a.sda;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_sys);
    end while (wb_ack !== 1'h1);
    q = wb_rdat;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask
  // One link command; data bytes fed as the master asks
  task automatic xfer(input logic [2:0] cs, input logic [7:0] fl,
                      input logic [15:0] a, input int n, output logic nk);
    logic [31:0] q;
    wb(1'h1, EE_REG_ADDR, {16'h0, a}, q);
    if (n > 0) wb(1'h1, EE_REG_DATA, 32'hC3, q);
    wb(1'h1, EE_REG_CMD, {16'h0, 8'(n), fl | 8'h20 | {5'h0, cs}}, q);
    for (int k = 1; k < n; k++) begin
      do begin
        wb(1'h0, EE_REG_STAT, 32'h0, q);
      end while (q[EE_ST_FULL] !== 1'h0);
      wb(1'h1, EE_REG_DATA, 32'(k), q);
    end
    do begin
      wb(1'h0, EE_REG_STAT, 32'h0, q);
    end while (q[EE_ST_BUSY] !== 1'h0);
    nk = q[EE_ST_NACK];
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wait_idle();
    while (d_busy !== 1'h0) begin
      @(posedge clk_sys);
    end
  endtask
  // Raw line driver on the second link
  task automatic bb_line(input logic c, input logic d);
    bus_b.scl_m_oe <= c;
    bus_b.sda_m_oe <= d;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic bb_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bb_line(1'h1, !b[i]);
      bb_line(1'h0, !b[i]);
    end
    bb_line(1'h1, 1'h0);
    bb_line(1'h0, 1'h0);
    a = bus_b.sda;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_byte();
    logic nk;
    xfer(CS, 8'h00, 16'hF123, 1, nk);
    chk1("write ack", 1'h0, nk);
    chk8("control", {EE_DEV_CODE, CS, 1'h0}, seen[0]);
    chk8("addr high", 8'hF1, seen[1]);
    chk8("addr low", 8'h23, seen[2]);
    chk8("byte data", 8'hC3, u_ee_dev.mem[12'h123]);
    chk1("host idle", 1'h0, h_busy);
    chk1("write busy", 1'h1, d_busy);
    xfer(CS, 8'h10, 16'h0000, 0, nk);
    chk1("poll busy", 1'h1, nk);
    wait_idle();
    xfer(CS, 8'h10, 16'h0000, 0, nk);
    chk1("poll done", 1'h0, nk);
  endtask
  task automatic t_sel();
    logic nk;
    for (int c = 0; c < 8; c++) begin
      xfer(3'(c), 8'h10, 16'h0000, 0, nk);
      chk1("select", logic'(3'(c) != CS), nk);
    end
  endtask
  task automatic t_page();
    logic nk;
    xfer(CS, 8'h00, 16'hFF1E, 34, nk);
    chk1("page ack", 1'h0, nk);
    chk1("page busy", 1'h1, d_busy);
    chk8("page wrap", 8'h20, u_ee_dev.mem[12'hF1E]);
    chk8("page roll", 8'h02, u_ee_dev.mem[12'hF00]);
    wait_idle();
    xfer(CS, 8'h00, 16'h0040, 0, nk);
    chk1("addr ack", 1'h0, nk);
    chk1("no write", 1'h0, d_busy);
  endtask
  task automatic t_wp();
    logic nk;
    wp <= 1'h1;
    xfer(CS, 8'h00, 16'h0200, 1, nk);
    chk1("wp ack", 1'h0, nk);
    chk1("wp idle", 1'h0, d_busy);
    xfer(CS, 8'h10, 16'h0000, 0, nk);
    chk1("wp ready", 1'h0, nk);
    wp <= 1'h0;
    xfer(CS, 8'h00, 16'h0200, 1, nk);
    chk1("wp off", 1'h1, d_busy);
    chk8("wp data", 8'hC3, u_ee_dev.mem[12'h200]);
    chk8("counter", 8'h01, u_ee_dev.q.addr[7:0]);
    wait_idle();
  endtask
  task automatic t_raw();
    logic a;
    bb_line(1'h0, 1'h1);
    bb_line(1'h1, 1'h1);
    bb_byte(8'h5A, a);
    chk1("bad code", 1'h1, a);
    bb_line(1'h1, 1'h1);
    bb_line(1'h0, 1'h1);
    bb_line(1'h0, 1'h0);
    bb_line(1'h0, 1'h1);
    bb_line(1'h1, 1'h1);
    bb_byte({EE_DEV_CODE, CS, 1'h1}, a);
    chk1("read ack", 1'h0, a);
    bb_byte(8'hFF, a);
    bb_line(1'h1, 1'h1);
    bb_line(1'h0, 1'h1);
    bb_line(1'h0, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    bus_b.scl_m_o  = 1'h0;
    bus_b.sda_m_o  = 1'h0;
    bus_b.scl_m_oe = 1'h0;
    bus_b.sda_m_oe = 1'h0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    t_byte();
    t_sel();
    t_page();
    t_wp();
    t_raw();
    summarize();
  end
endmodule
`default_nettype wire
